// File: hw/rbrs_pkg.sv
// Package for the reset and bus-reset sequencer: timing constants,
// sequencer states and the grouped pad-control carrier.
// Assumes a 100 MHz core clock; all times but the host wait convert to cycles here.
package rbrs_pkg;

   localparam int unsigned CLK_MHZ            = 100;
   // Least external reset low time, microseconds.
   localparam int unsigned T_RST_MIN_US       = 1;
   localparam int unsigned RST_MIN_CYC        = T_RST_MIN_US * CLK_MHZ;
   // Longest stabilization after release, microseconds.
   localparam int unsigned T_STAB_MAX_US      = 500;
   localparam int unsigned STAB_CYC           = T_STAB_MAX_US * CLK_MHZ;
   // Longest configuration load, milliseconds.
   localparam int unsigned T_CFG_MAX_MS       = 50;
   localparam int unsigned CFG_MAX_CYC        = T_CFG_MAX_MS * 1000 * CLK_MHZ;
   // Latest attach after release, milliseconds.
   localparam int unsigned T_ATTACH_MAX_MS    = 100;
   localparam int unsigned ATTACH_MAX_CYC     = T_ATTACH_MAX_MS*1000*CLK_MHZ;
   // Least host wait after attach, milliseconds (kept by the host).
   localparam int unsigned T_HOST_WAIT_MS     = 100;
   // Longest time to ready after bus reset and idle, milliseconds.
   localparam int unsigned T_READY_MAX_MS     = 5;
   localparam int unsigned READY_MAX_CYC      = T_READY_MAX_MS*1000*CLK_MHZ;
   // Restart pulse of the processor after a bus reset, cycles.
   localparam int unsigned CPU_RESTART_CYC    = 16;

   localparam logic [6:0] BUS_ADDR_RST        = 7'h00;
   localparam int unsigned CNT_W              = 32;

   typedef enum logic [5:0] {
      ST_RESET   = 6'h01,
      ST_STAB    = 6'h02,
      ST_CONFIG  = 6'h04,
      ST_ATTACH  = 6'h08,
      ST_BUSRST  = 6'h10,
      ST_READY   = 6'h20
   } rbrs_state_t;

   // Pad controls applied to the chip's pins.
   typedef struct packed {
      logic media_oe;           // media data/control driver enable
      logic media_ie;           // media data/control input buffer enable
      logic bus_xcvr_en;        // differential pair transceiver enable
      logic card_power_switch;  // card-power pad output enable
      logic detect_pullup_en;   // card-detect pull-ups
      logic activity_lamp_output;
      logic write_protect_sense;
      logic gpo_level;          // other general-purpose outputs
   } rbrs_pads_t;

endpackage : rbrs_pkg

// File: hw/rbrs_rst_sync.sv
// Reset release synchroniser with PLL-lock qualification.
// Assumes resetn_i is asynchronous; lock_i is synchronous to core_clk_i.
`timescale 1ns/1ps
module rbrs_rst_sync (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   // Qualifier
   input  wire logic lock_i,
   // Synchronised reset
   output logic      rst_done_o
);
   logic meta_r;
   logic sync_r;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= 1'b1;
         sync_r <= meta_r;
      end
   end

   // Internal logic stays held until the clock source reports lock.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_done_o <= 1'b0;
      end else begin
         rst_done_o <= sync_r & lock_i;
      end
   end
endmodule : rbrs_rst_sync

// File: hw/rbrs_sequencer.sv
// Reset and bus-reset sequencer for a bus-powered card reader controller.
// Assumes the board holds resetn_i low long enough with valid supplies,
// and that the bus core reports bus reset and idle as synchronous levels.
`timescale 1ns/1ps

// Contract
// - Reset disables transceiver, bus pair high-Z.
// - Reset aborts transactions, no saved state.
// - Reset returns all registers to defaults.
// - Reset stops oscillator and PLL.
// - Reset holds processor and media interfaces.
// - Stabilize 500 us, config 50 ms, attach 100 ms.
// - Ready within 5 ms after bus reset idle.
// - Bus reset: address zero, unconfigured.
// - Bus reset stops transactions, restarts processor.
// - Bus reset disables media, keeps clocks running.
// - Default option loads built-in configuration.
// - Reset pad states: Z, inputs, pull-ups, lows.
module rbrs_sequencer
   import rbrs_pkg::*;
#(
   parameter int unsigned STAB_CYCLES   = STAB_CYC,
   parameter int unsigned CFG_CYCLES    = CFG_MAX_CYC,
   parameter int unsigned ATTACH_CYCLES = ATTACH_MAX_CYC,
   parameter int unsigned READY_CYCLES  = READY_MAX_CYC
) (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       resetn_i,
   // Clock source status
   input  wire logic       pll_lock_i,
   // Configuration source
   input  wire logic       default_cfg_sel_i,
   input  wire logic       cfg_load_done_i,
   // Bus core status
   input  wire logic       bus_reset_i,
   input  wire logic       bus_idle_i,
   input  wire logic       cpu_ready_i,
   // Clock control
   output logic            osc_en_o,
   output logic            pll_en_o,
   // Processor and media control
   output logic            cpu_rst_n_o,
   output logic            media_rst_n_o,
   output logic            media_en_o,
   output logic            xact_abort_o,
   output logic            cfg_use_default_o,
   output logic            cfg_load_ext_o,
   // Bus device state
   output logic            bus_attach_o,
   output logic [6:0]      bus_addr_o,
   output logic            configured_o,
   output logic            dev_ready_o,
   output logic            seq_timeout_o,
   // Pads
   output rbrs_pads_t      pads_o
);

   logic        rst_done;
   rbrs_state_t state_r;
   rbrs_state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] attach_cnt_r;
   logic [4:0]  cpu_hold_r;
   logic        bus_reset_d_r;
   logic        bus_reset_rise;

   rbrs_rst_sync u_rst_sync (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .lock_i     (pll_lock_i),
      .rst_done_o (rst_done)
   );

   assign bus_reset_rise = bus_reset_i & ~bus_reset_d_r;

   // Clocks run whenever the pin is released; they stop only on the pin.
   // Oscillator and PLL halt.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         osc_en_o <= 1'b0;
         pll_en_o <= 1'b0;
      end else begin
         osc_en_o <= 1'b1;
         pll_en_o <= 1'b1;
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: begin
            if (rst_done) begin
               state_nxt = ST_STAB;
            end
         end
         ST_STAB: begin
            if (cnt_r >= STAB_CYCLES - 1) begin
               state_nxt = ST_CONFIG;
            end
         end
         ST_CONFIG: begin
            if (cfg_load_done_i || cnt_r >= CFG_CYCLES - 1) begin
               state_nxt = ST_ATTACH;
            end
         end
         ST_ATTACH: begin
            if (bus_reset_i) begin
               state_nxt = ST_BUSRST;
            end
         end
         ST_BUSRST: begin
            if (cpu_ready_i && bus_idle_i && !bus_reset_i
                && cpu_hold_r == 5'h00) begin
               state_nxt = ST_READY;
            end
         end
         ST_READY: begin
            state_nxt = ST_READY;
         end
         default: begin
            state_nxt = ST_RESET;
         end
      endcase
      if (bus_reset_rise && state_r != ST_RESET && state_r != ST_STAB
          && state_r != ST_CONFIG) begin
         state_nxt = ST_BUSRST;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r       <= ST_RESET;
         bus_reset_d_r <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         bus_reset_d_r <= bus_reset_i;
      end
   end

   // Phase counter restarts at each state change.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r <= '0;
      end else if (state_nxt != state_r) begin
         cnt_r <= '0;
      end else if (cnt_r != {CNT_W{1'b1}}) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Attach deadline counted from entry to stabilize, across stabilize and config.
   // Attach by 100 ms.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         attach_cnt_r  <= '0;
         seq_timeout_o <= 1'b0;
      end else if (state_r == ST_STAB || state_r == ST_CONFIG) begin
         attach_cnt_r <= attach_cnt_r + 1'b1;
         if (attach_cnt_r >= ATTACH_CYCLES - 1) begin
            seq_timeout_o <= 1'b1;
         end
      end else if (state_r == ST_BUSRST && cnt_r >= READY_CYCLES - 1) begin
         seq_timeout_o <= 1'b1;
      end
   end

   // A short restart pulse keeps the processor reset held on a bus reset.
   // Processor restart.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cpu_hold_r <= 5'h00;
      end else if (bus_reset_rise && state_r != ST_RESET) begin
         cpu_hold_r <= 5'(CPU_RESTART_CYC);
      end else if (cpu_hold_r != 5'h00) begin
         cpu_hold_r <= cpu_hold_r - 5'h01;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cpu_rst_n_o   <= 1'b0;
         media_rst_n_o <= 1'b0;
         media_en_o    <= 1'b0;
         xact_abort_o  <= 1'b1;
      end else begin
         cpu_rst_n_o   <= (state_nxt != ST_RESET) && !(bus_reset_rise
                          && state_r != ST_RESET) && (cpu_hold_r <= 5'h01);
         media_rst_n_o <= (state_nxt != ST_RESET);
         media_en_o    <= (state_nxt == ST_READY);
         xact_abort_o  <= (state_nxt == ST_RESET) || (state_nxt == ST_BUSRST);
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_use_default_o <= 1'b0;
         cfg_load_ext_o    <= 1'b0;
      end else begin
         cfg_use_default_o <= (state_nxt == ST_CONFIG) && default_cfg_sel_i;
         cfg_load_ext_o    <= (state_nxt == ST_CONFIG) && !default_cfg_sel_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_addr_o   <= BUS_ADDR_RST;
         configured_o <= 1'b0;
         dev_ready_o  <= 1'b0;
      end else begin
         if (bus_reset_i) begin
            bus_addr_o   <= BUS_ADDR_RST;
            configured_o <= 1'b0;
         end
         dev_ready_o <= (state_nxt == ST_READY);
      end
   end

   // The host-side 100 ms wait is not enforced here; attach simply stays
   // up while the host waits, through its bus reset and on into ready.
   // Attach held for host.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_attach_o <= 1'b0;
      end else begin
         bus_attach_o <= (state_nxt == ST_ATTACH) || (state_nxt == ST_BUSRST)
                         || (state_nxt == ST_READY);
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pads_o <= '{media_oe: 1'b0, media_ie: 1'b0, bus_xcvr_en: 1'b0,
                     card_power_switch: 1'b0, detect_pullup_en: 1'b1,
                     activity_lamp_output: 1'b0, write_protect_sense: 1'b0,
                     gpo_level: 1'b0};
      end else begin
         pads_o.media_oe             <= (state_nxt == ST_READY);
         pads_o.media_ie             <= (state_nxt == ST_READY);
         pads_o.bus_xcvr_en          <= bus_attach_o
                                        | (state_nxt == ST_ATTACH);
         pads_o.card_power_switch    <= (state_nxt == ST_READY);
         pads_o.detect_pullup_en     <= 1'b1;
         pads_o.activity_lamp_output <= 1'b0;
         pads_o.write_protect_sense  <= 1'b0;
         pads_o.gpo_level            <= 1'b0;
      end
   end

endmodule : rbrs_sequencer

// File: dv/rbrs_sequencer_checker.sv
// Concurrent checks on the sequencer's top ports.
// Assumes the config select changes only while reset is held.
`timescale 1ns/1ps
module rbrs_sequencer_checker
   import rbrs_pkg::*;
#(
   parameter int unsigned ATTACH_CYCLES = ATTACH_MAX_CYC
) (
   // Clock, reset and watched inputs
   input wire logic       core_clk_i,
   input wire logic       resetn_i,
   input wire logic       pll_lock_i,
   input wire logic       default_cfg_sel_i,
   input wire logic       bus_reset_i,
   // Watched clock and processor controls
   input wire logic       osc_en_o,
   input wire logic       pll_en_o,
   input wire logic       cpu_rst_n_o,
   input wire logic       media_rst_n_o,
   input wire logic       media_en_o,
   input wire logic       xact_abort_o,
   input wire logic       cfg_use_default_o,
   input wire logic       cfg_load_ext_o,
   // Watched bus state and pads
   input wire logic       bus_attach_o,
   input wire logic       configured_o,
   input wire logic       dev_ready_o,
   input wire logic       seq_timeout_o,
   input wire logic [6:0] bus_addr_o,
   input wire rbrs_pads_t pads_o
);
   localparam rbrs_pads_t RST_PADS = 8'h08;
   logic [15:0] lock_cyc_r;

   // Counts locked cycles since release; saturates instead of wrapping.
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) lock_cyc_r <= 16'h0000;
      else if (pll_lock_i && lock_cyc_r != 16'hFFFF)
         lock_cyc_r <= lock_cyc_r + 16'h0001;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   a_clocks_halted: assert property (
      $rose(resetn_i) |-> !osc_en_o && !pll_en_o)
      else $error("clocks ran in reset");
   a_pads_reset: assert property (
      $rose(resetn_i) |-> pads_o == RST_PADS) else $error("pads wrong");
   a_xcvr_off: assert property (
      $rose(resetn_i) |-> !pads_o.bus_xcvr_en) else $error("xcvr on");
   a_cpu_held: assert property (
      $rose(resetn_i) |-> !cpu_rst_n_o && !media_rst_n_o)
      else $error("cpu or media ran in reset");
   a_abort_reset: assert property (
      $rose(resetn_i) |-> xact_abort_o && bus_addr_o == 7'h00 && !dev_ready_o)
      else $error("work not aborted in reset");
   a_addr_cleared: assert property (
      $rose(bus_reset_i) && bus_attach_o |->
      ##[1:2] (bus_addr_o == 7'h00 && !configured_o))
      else $error("address kept over bus reset");
   a_cpu_restart: assert property (
      $rose(bus_reset_i) && bus_attach_o |->
      ##[1:2] (!cpu_rst_n_o && xact_abort_o))
      else $error("cpu not restarted");
   a_media_off: assert property (
      $rose(bus_reset_i) && bus_attach_o |->
      ##2 (!media_en_o && osc_en_o && pll_en_o))
      else $error("media on or clocks off in bus reset");
   a_ready_time: assert property (
      $fell(bus_reset_i) && xact_abort_o |-> ##[1:40] dev_ready_o)
      else $error("ready late");
   a_cfg_select: assert property (
      cfg_use_default_o || cfg_load_ext_o |-> cfg_use_default_o ==
      default_cfg_sel_i && cfg_load_ext_o != default_cfg_sel_i)
      else $error("config source wrong");
   a_attach_bound: assert property (
      lock_cyc_r == ATTACH_CYCLES + 4 |-> bus_attach_o || seq_timeout_o)
      else $error("attach late");
   a_lock_gate: assert property (
      lock_cyc_r < 16'h0002 |-> !cpu_rst_n_o && !bus_attach_o)
      else $error("left reset before lock");
endmodule : rbrs_sequencer_checker

bind rbrs_sequencer rbrs_sequencer_checker #(
   .ATTACH_CYCLES(ATTACH_CYCLES)
) u_chk (.core_clk_i, .resetn_i, .pll_lock_i, .default_cfg_sel_i,
   .bus_reset_i, .osc_en_o, .pll_en_o, .cpu_rst_n_o, .media_rst_n_o,
   .media_en_o, .xact_abort_o, .cfg_use_default_o, .cfg_load_ext_o,
   .bus_attach_o, .configured_o, .dev_ready_o, .seq_timeout_o,
   .bus_addr_o, .pads_o);

// File: dv/rbrs_host_model.sv
// Upstream host and processor model facing the sequencer.
// Assumes one bus reset per attach, plus any the bench kicks.
`timescale 1ns/1ps
module rbrs_host_model #(
   parameter int unsigned WAIT_CYC = 30
) (
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   input  wire logic bus_attach_i,
   input  wire logic cpu_rst_n_i,
   input  wire logic kick_i,
   output logic      bus_reset_o,
   output logic      bus_idle_o,
   output logic      cpu_ready_o
);
   int unsigned wait_r;
   logic [3:0]  len_r;
   logic        done_r;
   logic [1:0]  cpu_r;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_r <= 0;
         len_r  <= 4'h0;
         done_r <= 1'b0;
         cpu_r  <= 2'h0;
      end else begin
         cpu_r <= {cpu_r[0], cpu_rst_n_i};
         if (kick_i) len_r <= 4'h8;
         else if (len_r != 4'h0) len_r <= len_r - 4'h1;
         else if (bus_attach_i && !done_r) begin
            wait_r <= wait_r + 1;
            if (wait_r == WAIT_CYC) begin
               len_r  <= 4'h8;
               done_r <= 1'b1;
            end
         end
      end
   end
   assign bus_reset_o = (len_r != 4'h0);
   assign bus_idle_o  = done_r && (len_r == 4'h0);
   assign cpu_ready_o = cpu_r[1];
endmodule : rbrs_host_model

// File: dv/rbrs_sequencer_tb.sv
// Self-checking bench for the reset and bus-reset sequencer.
// Assumes the host model answers each attach with a bus reset.
`timescale 1ns/1ps
module rbrs_sequencer_tb
   import rbrs_pkg::*;
;
   localparam rbrs_pads_t RST_PADS = 8'h08;
   logic core_clk_i, resetn_i, pll_lock_i, sel, cfg_done, kick;
   logic osc, pll, cpu_n, med_n, med_en, abort, use_def, ext;
   logic attach, conf, ready, tmo, bus_rst, idle, cpu_rdy;
   logic [6:0] addr;
   rbrs_pads_t pads;
   int err_total, checked, tick_cnt;

   rbrs_sequencer #(.STAB_CYCLES(20), .CFG_CYCLES(40),
      .ATTACH_CYCLES(100), .READY_CYCLES(50)) u_dut (
      .core_clk_i, .resetn_i, .pll_lock_i,
      .default_cfg_sel_i(sel), .cfg_load_done_i(cfg_done),
      .bus_reset_i(bus_rst), .bus_idle_i(idle), .cpu_ready_i(cpu_rdy),
      .osc_en_o(osc), .pll_en_o(pll), .cpu_rst_n_o(cpu_n),
      .media_rst_n_o(med_n), .media_en_o(med_en), .xact_abort_o(abort),
      .cfg_use_default_o(use_def), .cfg_load_ext_o(ext),
      .bus_attach_o(attach), .bus_addr_o(addr), .configured_o(conf),
      .dev_ready_o(ready), .seq_timeout_o(tmo), .pads_o(pads));
   rbrs_host_model #(.WAIT_CYC(30)) u_host (.core_clk_i, .resetn_i,
      .bus_attach_i(attach), .cpu_rst_n_i(cpu_n), .kick_i(kick),
      .bus_reset_o(bus_rst), .bus_idle_o(idle), .cpu_ready_o(cpu_rdy));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run();
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   task automatic t_reset();
      @(posedge core_clk_i);
      resetn_i <= 1'b0;
      pll_lock_i <= 1'b0;
      cfg_done <= 1'b0;
      kick <= 1'b0;
      repeat (RST_MIN_CYC) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(pads, RST_PADS);
      chk({7'h00, pads.bus_xcvr_en}, 8'h00);
      chk({6'h00, osc, pll}, 8'h00);
      chk({5'h00, cpu_n, med_n, abort}, 8'h01);
      chk({1'b0, addr}, {1'b0, BUS_ADDR_RST});
      chk({7'h00, ready}, 8'h00);
   endtask : t_reset

   task automatic t_up(input logic s, input int dly, input logic done);
      time t0;
      @(posedge core_clk_i);
      sel <= s;
      resetn_i <= 1'b1;
      pll_lock_i <= (dly == 0);
      t0 = $time;
      if (dly > 0) begin
         repeat (dly) @(negedge core_clk_i);
         chk({6'h00, cpu_n, attach}, 8'h00);
         @(posedge core_clk_i);
         pll_lock_i <= 1'b1;
         t0 = $time;
      end
      repeat (60) if (!(use_def | ext)) @(negedge core_clk_i);
      chk({6'h00, use_def, ext}, {6'h00, s, !s});
      chk({7'h00, ($time - t0) < 300}, 8'h01);
      @(posedge core_clk_i);
      cfg_done <= done;
      repeat (80) if (attach !== 1'b1) @(negedge core_clk_i);
      chk({6'h00, attach, pads.bus_xcvr_en}, 8'h03);
      chk({7'h00, ($time - t0) < 1000}, 8'h01);
      repeat (80) if (idle !== 1'b1) @(negedge core_clk_i);
      t0 = $time;
      repeat (60) if (ready !== 1'b1) @(negedge core_clk_i);
      chk({7'h00, ($time - t0) < 500}, 8'h01);
      chk({ready, med_en, cpu_n, conf, tmo, med_n, 2'h0}, 8'hE4);
   endtask : t_up

   task automatic t_busrst(input logic settle);
      @(posedge core_clk_i);
      kick <= 1'b1;
      @(posedge core_clk_i);
      kick <= 1'b0;
      repeat (3) @(negedge core_clk_i);
      chk({5'h00, ready, cpu_n, abort}, 8'h01);
      chk({5'h00, med_en, osc, pll}, 8'h03);
      chk({conf, addr}, 8'h00);
      if (settle) begin
         repeat (60) if (ready !== 1'b1) @(negedge core_clk_i);
         chk({6'h00, ready, med_en}, 8'h03);
      end
   endtask : t_busrst

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i) begin
      tick_cnt++;
      if (tick_cnt == 5000) begin
         err_total++;
         complete_run();
      end
   end

   initial begin
      resetn_i <= 1'b0;
      pll_lock_i <= 1'b0;
      sel <= 1'b1;
      cfg_done <= 1'b0;
      kick <= 1'b0;
      t_reset();
      t_up(1'b1, 10, 1'b1);
      t_busrst(1'b1);
      t_reset();
      t_up(1'b0, 0, 1'b0);
      t_busrst(1'b0);
      t_reset();
      t_up(1'b0, 0, 1'b1);
      complete_run();
   end
endmodule : rbrs_sequencer_tb
